// ### obd_defs.vh
// Constants for the option byte and bootstrap decode block.
// Assumes it is included by bare name from the design files.
`ifndef OBD_DEFS_VH
`define OBD_DEFS_VH

// Register indices; byte address is four times the index
`define OBD_IDX_OPTION    16'h7FDE
`define OBD_IDX_CTRL      16'h0000
`define OBD_IDX_STAT      16'h0001
`define OBD_ADDR_W        18

// Option byte field positions
`define OBD_OPT_WOI       7
`define OBD_OPT_DIVA      6
`define OBD_OPT_DIVB      5
`define OBD_OPT_RESET_STRETCH_SELECT      4
`define OBD_OPT_WATCHDOG_ON_AFTER_RESET      3
`define OBD_OPT_WATCHDOG_ON_IN_WAIT      2
`define OBD_OPT_PORT_B_PULLDOWN_ENABLE      1
`define OBD_OPT_PORT_C_PULLDOWN_ENABLE      0

// Control register fields and reset value
`define OBD_CTRL_WIRED_OR_SOFT_ENABLE     0
`define OBD_CTRL_RST      32'h0000_0000

// Status register fields
`define OBD_ST_BOOT       0
`define OBD_ST_WDOG       1
`define OBD_ST_INRST      2
`define OBD_ST_DIV_LO     4

// Clock divide ratios
`define OBD_DIV_2         4'h2
`define OBD_DIV_4         4'h4
`define OBD_DIV_8         4'h8
`define OBD_DIV_10        4'hA

// Power-on reset stretch, in cycles of the device clock
`define OBD_POR_SHORT     12'h010
`define OBD_POR_LONG      12'hFE0

// Bootstrap ROM windows and vectors
`define OBD_ROM0_LO       16'h0200
`define OBD_ROM0_HI       16'h024F
`define OBD_ROM1_LO       16'h03B0
`define OBD_ROM1_HI       16'h3FFF
`define OBD_ROM2_LO       16'h7E00
`define OBD_ROM2_HI       16'h7FDD
`define OBD_ROM3_LO       16'h7FE0
`define OBD_ROM3_HI       16'h7FEF
`define OBD_BOOT_VEC      16'h7FEE
`define OBD_USER_VEC      16'hFFFE

// AXI responses
`define OBD_RESP_OKAY     2'b00
`define OBD_RESP_SLVERR   2'b10

`endif

// ### obd_pulldown.v
// Per-port pull-down enable generator, one instance per port.
// Assumes direction bits are high for output pins.
`timescale 1ns/1ps
`default_nettype none
module obd_pulldown (
  // Clock and reset
  input  wire       sys_clk_in,
  input  wire       nrst_in,
  // Option and direction
  input  wire       enable_in,
  input  wire [7:0] dir_out_in,
  // Pull-down enables
  output reg  [7:0] pulldown_out
);

  ////////////////////////////////////////////////////////////////////////////
  // A pull-down only loads a pin that nothing drives
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pulldown_out <= 8'h00;
    end else begin
      pulldown_out <= {8{enable_in}} & ~dir_out_in;
    end
  end

endmodule
`default_nettype wire

// ### obd_top.v
// Option byte decode, reset stretch and bootstrap entry detection.
// Assumes synchronous pins, an AXI4-Lite master and a non-volatile option byte input.
// Operation
// - Wired-OR interrupt needs both option enable and soft enable set.
// - Wired-OR source is every port B pin configured as input.
// - Soft wired-OR enable forced to zero while option enable is clear.
// - Divider: both set 2, a only 4, b only 8, none 10.
// - Bootstrap mode forces divide ratio two.
// - After power-on hold reset pin low 16 or 4064 cycles.
// - Watchdog-after-reset bit set runs watchdog after reset, except bootstrap.
// - Watchdog-after-reset bit clear leaves watchdog disabled after reset.
// - Watchdog-in-wait bit chooses counting or disabled during wait.
// - Port B pull-down enabled per input pin when option set.
// - Port C pull-down enabled per input pin when option set.
// - No reset alters the option byte bits.
// - Bootstrap keeps all options except divide ratio and watchdog-after-reset as programmed.
// - Bootstrap on reset rise: high-volt irq or mode pin, cap1 high, cap2 low.
// - Bootstrap start address fetched from vector at 7FEE and 7FEF.
// - Bootstrap ROM mapped at four documented address windows.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "obd_defs.vh"
module obd_top (
  // Clock and reset
  input  wire                   sys_clk_in,
  input  wire                   nrst_in,
  // Non-volatile option byte
  input  wire [7:0]             option_byte_in,
  // Reset pin, open drain
  input  wire                   reset_pin_in,
  output reg                    reset_pin_out,
  output reg                    reset_pin_oe_out,
  // Bootstrap selection pins
  input  wire                   irq_high_volt_in,
  input  wire                   mode_select_pin_in,
  input  wire                   capture_pin_one_in,
  input  wire                   capture_pin_two_in,
  // CPU side
  input  wire                   wait_mode_in,
  input  wire [15:0]            cpu_addr_in,
  output reg                    cpu_reset_out,
  output reg                    boot_mode_out,
  output reg  [15:0]            reset_vector_out,
  output reg                    boot_rom_sel_out,
  output reg  [3:0]             clock_div_out,
  output reg                    watchdog_run_out,
  // Ports
  input  wire [7:0]             port_b_pin_in,
  input  wire [7:0]             port_b_dir_in,
  input  wire [7:0]             port_c_dir_in,
  output wire [7:0]             port_b_pulldown_out,
  output wire [7:0]             port_c_pulldown_out,
  output reg                    wired_or_irq_out,
  // AXI4-Lite write address
  input  wire [`OBD_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // AXI4-Lite read address
  input  wire [`OBD_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready
);

  localparam [`OBD_ADDR_W-1:0] ADDR_OPTION = {`OBD_IDX_OPTION, 2'b00};
  localparam [`OBD_ADDR_W-1:0] ADDR_CTRL   = {`OBD_IDX_CTRL, 2'b00};
  localparam [`OBD_ADDR_W-1:0] ADDR_STAT   = {`OBD_IDX_STAT, 2'b00};

  // Reset sequencer states, one-hot
  localparam [3:0] ST_LOAD    = 4'b0001;
  localparam [3:0] ST_STRETCH = 4'b0010;
  localparam [3:0] ST_PIN     = 4'b0100;
  localparam [3:0] ST_RUN     = 4'b1000;

  reg  [3:0]  state_q;
  reg  [11:0] stretch_cnt_q;
  reg  [7:0]  opt_q;
  reg         boot_q;
  reg         wired_or_soft_enable_q;
  reg         aw_held_q;
  reg         w_held_q;
  reg  [`OBD_ADDR_W-1:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [3:0]  div_d;
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_d;
  wire        boot_entry;
  wire        wdog_base;
  wire        aw_take;
  wire        w_take;
  wire        wr_go;
  wire        ar_take;

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap entry condition, sampled while the reset pin rises
  assign boot_entry = (irq_high_volt_in | mode_select_pin_in) &
                      capture_pin_one_in & ~capture_pin_two_in;

  // Reset sequencer: capture, power-on stretch, wait for the pin, run.
  // The option byte is only read here, never written, so resets leave it alone.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q       <= ST_LOAD;
      stretch_cnt_q <= 12'h000;
      opt_q         <= 8'h00;
      boot_q        <= 1'b0;
    end else begin
      case (state_q)
        ST_LOAD: begin
          opt_q         <= option_byte_in;
          stretch_cnt_q <= option_byte_in[`OBD_OPT_RESET_STRETCH_SELECT] ?
                           `OBD_POR_SHORT : `OBD_POR_LONG;
          state_q       <= ST_STRETCH;
        end
        ST_STRETCH: begin
          if (stretch_cnt_q == 12'h001) begin
            state_q <= ST_PIN;
          end
          stretch_cnt_q <= stretch_cnt_q - 12'h001;
        end
        ST_PIN: begin
          // Pins hold three cycles past the rise, so this sample is safe
          if (reset_pin_in) begin
            opt_q   <= option_byte_in;
            boot_q  <= boot_entry;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          // External reset: no stretch, options recaptured on release
          if (!reset_pin_in) begin
            state_q <= ST_PIN;
          end
        end
        default: begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divide ratio decode; bootstrap overrides this setting and the watchdog-after-reset bit
  always @* begin
    case ({opt_q[`OBD_OPT_DIVA], opt_q[`OBD_OPT_DIVB]})
      2'b11:   div_d = `OBD_DIV_2;
      2'b10:   div_d = `OBD_DIV_4;
      2'b01:   div_d = `OBD_DIV_8;
      default: div_d = `OBD_DIV_10;
    endcase
    if (boot_q) begin
      div_d = `OBD_DIV_2;
    end
  end

  // Watchdog comes up running only with the bit set and outside bootstrap
  assign wdog_base = opt_q[`OBD_OPT_WATCHDOG_ON_AFTER_RESET] & ~boot_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward CPU, clock generator, watchdog and reset pin
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_pin_out    <= 1'b0;
      reset_pin_oe_out <= 1'b1;
      cpu_reset_out    <= 1'b1;
      boot_mode_out    <= 1'b0;
      reset_vector_out <= `OBD_USER_VEC;
      boot_rom_sel_out <= 1'b0;
      clock_div_out    <= `OBD_DIV_10;
      watchdog_run_out <= 1'b0;
      wired_or_irq_out <= 1'b0;
    end else begin
      reset_pin_out    <= 1'b0;
      reset_pin_oe_out <= (state_q == ST_LOAD) | (state_q == ST_STRETCH);
      cpu_reset_out    <= (state_q != ST_RUN);
      boot_mode_out    <= boot_q;
      reset_vector_out <= boot_q ? `OBD_BOOT_VEC : `OBD_USER_VEC;
      boot_rom_sel_out <= boot_q & (
        ((cpu_addr_in >= `OBD_ROM0_LO) & (cpu_addr_in <= `OBD_ROM0_HI)) |
        ((cpu_addr_in >= `OBD_ROM1_LO) & (cpu_addr_in <= `OBD_ROM1_HI)) |
        ((cpu_addr_in >= `OBD_ROM2_LO) & (cpu_addr_in <= `OBD_ROM2_HI)) |
        ((cpu_addr_in >= `OBD_ROM3_LO) & (cpu_addr_in <= `OBD_ROM3_HI)));
      clock_div_out    <= div_d;
      // Wait keeps the watchdog only when the wait option allows it
      watchdog_run_out <= (state_q == ST_RUN) & wdog_base &
                          (~wait_mode_in | opt_q[`OBD_OPT_WATCHDOG_ON_IN_WAIT]);
      // Port B input pins pulled low raise the wired-OR request
      wired_or_irq_out <= (state_q == ST_RUN) & opt_q[`OBD_OPT_WOI] & wired_or_soft_enable_q &
                          (|(~port_b_dir_in & ~port_b_pin_in));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pull-downs follow the captured option, even in bootstrap
  obd_pulldown u_pd_b (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .enable_in    (opt_q[`OBD_OPT_PORT_B_PULLDOWN_ENABLE]),
    .dir_out_in   (port_b_dir_in),
    .pulldown_out (port_b_pulldown_out)
  );

  obd_pulldown u_pd_c (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .enable_in    (opt_q[`OBD_OPT_PORT_C_PULLDOWN_ENABLE]),
    .dir_out_in   (port_c_dir_in),
    .pulldown_out (port_c_pulldown_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI write path: address and data caught in either order
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_go   = aw_held_q & w_held_q & ~s_axi_bvalid;

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OBD_RESP_OKAY;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= {`OBD_ADDR_W{1'b0}};
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      wired_or_soft_enable_q        <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~aw_take & ~s_axi_awready;
      s_axi_wready  <= ~w_held_q & ~w_take & ~s_axi_wready;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == ADDR_CTRL) ? `OBD_RESP_OKAY : `OBD_RESP_SLVERR;
        if ((aw_addr_q == ADDR_CTRL) & w_strb_q[0]) begin
          wired_or_soft_enable_q <= w_data_q[`OBD_CTRL_WIRED_OR_SOFT_ENABLE];
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Soft enable cannot stick while the option blocks it, nor across reset
      if (!opt_q[`OBD_OPT_WOI] | (state_q != ST_RUN)) begin
        wired_or_soft_enable_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read decode; unmapped addresses answer with an error and zero
  always @* begin
    rdata_d = 32'h0000_0000;
    rresp_d = `OBD_RESP_OKAY;
    case (s_axi_araddr)
      ADDR_OPTION: rdata_d[7:0] = opt_q;
      ADDR_CTRL:   rdata_d[`OBD_CTRL_WIRED_OR_SOFT_ENABLE] = wired_or_soft_enable_q;
      ADDR_STAT: begin
        rdata_d[`OBD_ST_BOOT]  = boot_q;
        rdata_d[`OBD_ST_WDOG]  = watchdog_run_out;
        rdata_d[`OBD_ST_INRST] = cpu_reset_out;
        rdata_d[`OBD_ST_DIV_LO+3:`OBD_ST_DIV_LO] = clock_div_out;
      end
      default:     rresp_d = `OBD_RESP_SLVERR;
    endcase
  end

  assign ar_take = s_axi_arvalid & s_axi_arready;

  // One read at a time: ready drops while the answer stands
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OBD_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_d;
        s_axi_rresp  <= rresp_d;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### obd_top_properties.sv
// Port-level checks for the option byte decode block, bound into obd_top.
// Assumes option_byte_in only changes while nrst_in is low.
`timescale 1ns/1ps
`default_nettype none
`include "obd_defs.vh"
module obd_top_properties (
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  // Watched inputs
  input wire logic [7:0]  option_byte_in,
  input wire logic        irq_high_volt_in,
  input wire logic        mode_select_pin_in,
  input wire logic        capture_pin_one_in,
  input wire logic        capture_pin_two_in,
  input wire logic        wait_mode_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic [7:0]  port_b_pin_in,
  input wire logic [7:0]  port_b_dir_in,
  // Watched outputs
  input wire logic        reset_pin_oe_out,
  input wire logic        cpu_reset_out,
  input wire logic        boot_mode_out,
  input wire logic [15:0] reset_vector_out,
  input wire logic        boot_rom_sel_out,
  input wire logic [3:0]  clock_div_out,
  input wire logic        watchdog_run_out,
  input wire logic [7:0]  port_b_pulldown_out,
  input wire logic        wired_or_irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Expected decode of option byte, pins and address
  wire        run = ~cpu_reset_out;
  wire [1:0]  ds  = option_byte_in[6:5];
  wire [3:0]  dx  = ds == 2'h3 ? `OBD_DIV_2 : ds == 2'h2 ? `OBD_DIV_4 :
                    ds == 2'h1 ? `OBD_DIV_8 : `OBD_DIV_10;
  wire        bc  = (irq_high_volt_in | mode_select_pin_in) & capture_pin_one_in
                    & ~capture_pin_two_in;
  wire        src = |(~port_b_dir_in & ~port_b_pin_in);
  wire [15:0] a   = cpu_addr_in;
  wire        rom = (a >= `OBD_ROM0_LO && a <= `OBD_ROM0_HI) || (a >= `OBD_ROM1_LO &&
                    a <= `OBD_ROM1_HI) || (a >= `OBD_ROM2_LO && a <= `OBD_ROM2_HI) ||
                    (a >= `OBD_ROM3_LO && a <= `OBD_ROM3_HI);
  // Edges the pin has been held low since release; a range allows the two-cycle lag
  logic [12:0] oe_cnt_q;
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) oe_cnt_q <= 13'h0000;
    else oe_cnt_q <= reset_pin_oe_out ? oe_cnt_q + 13'h0001 : 13'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  stretch_len_a: assert property ($fell(reset_pin_oe_out) |-> oe_cnt_q >= (option_byte_in[4] ?
    16 : 4064) && oe_cnt_q <= (option_byte_in[4] ? 20 : 4068)) else $error("stretch length");
  irq_gate_a: assert property (wired_or_irq_out |-> option_byte_in[7])
    else $error("wired-or irq without option");
  irq_source_a: assert property (wired_or_irq_out |-> $past(src))
    else $error("wired-or irq without low input pin");
  div_user_a: assert property (run && !boot_mode_out |-> clock_div_out == dx)
    else $error("divide ratio mismatch");
  div_boot_a: assert property (boot_mode_out |-> clock_div_out == `OBD_DIV_2)
    else $error("boot divide not two");
  boot_entry_a: assert property ($fell(cpu_reset_out) |-> boot_mode_out == $past(bc))
    else $error("boot entry decision wrong");
  vector_sel_a: assert property (run |-> reset_vector_out ==
    (boot_mode_out ? `OBD_BOOT_VEC : `OBD_USER_VEC)) else $error("reset vector wrong");
  wdog_after_a: assert property (watchdog_run_out && run |-> option_byte_in[3] && !boot_mode_out)
    else $error("watchdog running when off");
  wdog_wait_a: assert property (watchdog_run_out && $past(wait_mode_in) |-> option_byte_in[2])
    else $error("watchdog running in wait");
  pulldown_b_a: assert property (run && $past(run) |-> port_b_pulldown_out ==
    (option_byte_in[1] ? ~$past(port_b_dir_in) : 8'h00)) else $error("port b pull-down");
  rom_sel_a: assert property (run && $past(run) |-> boot_rom_sel_out ==
    ($past(boot_mode_out) && $past(rom))) else $error("boot rom select");
endmodule
bind obd_top obd_top_properties obd_top_properties_inst (.*);
`default_nettype wire

// ### obd_pin_partner.sv
// Parties on the open-drain reset pin and the bootstrap selection pins.
// Assumes a pull-up on the reset pin; selection levels come from the bench.
`timescale 1ns/1ps
`default_nettype none
module obd_pin_partner (
  // Clock
  input  wire logic       sys_clk_in,
  // Pin control
  input  wire logic       ext_low_in,
  input  wire logic [3:0] sel_in,
  input  wire logic       pin_oe_in,
  // Resolved pins
  output wire logic       pin_level_out,
  output var  logic [3:0] sel_pins_out
);
  // Pull-up wins unless a party pulls the pin low
  assign pin_level_out = ~(pin_oe_in | ext_low_in);
  // Levels held three cycles past the rise only, then inverted to expose late sampling
  logic [1:0] hold_q;
  always @(posedge sys_clk_in) begin
    if (!pin_level_out) hold_q <= 2'h0;
    else if (hold_q != 2'h3) hold_q <= hold_q + 2'h1;
    sel_pins_out <= (hold_q == 2'h3) ? ~sel_in : sel_in;
  end
endmodule
`default_nettype wire

// ### tb.sv
// Register-level bench for the option byte decode block.
// Assumes the checker is bound in and the pin partner models the reset pin.
`timescale 1ns/1ps
`default_nettype none
`include "obd_defs.vh"
module tb;
  logic sys_clk_in, nrst_in, ext_low, wait_mode_in, bt, wd;
  logic [7:0] option_byte_in, port_b_pin_in, port_b_dir_in, port_c_dir_in, o;
  logic [3:0] sel, s, ed, s_axi_wstrb;
  logic [15:0] cpu_addr_in;
  wire reset_pin_in, reset_pin_out, reset_pin_oe_out, cpu_reset_out, boot_mode_out;
  wire boot_rom_sel_out, watchdog_run_out, wired_or_irq_out;
  wire irq_high_volt_in, mode_select_pin_in, capture_pin_one_in, capture_pin_two_in;
  wire [15:0] reset_vector_out;
  wire [3:0] clock_div_out, selp;
  wire [7:0] port_b_pulldown_out, port_c_pulldown_out;
  logic [`OBD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer failures, tests_run, i, n_st;
  localparam logic [7:0] OPTS [0:5] = '{8'hDB, 8'hF4, 8'hBE, 8'h1D, 8'h9F, 8'h4B};
  localparam logic [3:0] SELS [0:5] = '{4'h0, 4'h3, 4'h7, 4'h2, 4'hA, 4'h6};
  localparam logic [17:0] A_OPT = {`OBD_IDX_OPTION, 2'h0};
  localparam logic [17:0] A_CTL = {`OBD_IDX_CTRL, 2'h0};
  localparam logic [17:0] A_ST = {`OBD_IDX_STAT, 2'h0};
  assign {irq_high_volt_in, mode_select_pin_in, capture_pin_one_in, capture_pin_two_in} = selp;
  obd_top obd_top_inst (.*);
  obd_pin_partner obd_pin_partner_inst (.sys_clk_in(sys_clk_in), .ext_low_in(ext_low),
    .sel_in(sel), .pin_oe_in(reset_pin_oe_out), .pin_level_out(reset_pin_in), .sel_pins_out(selp));
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task chk(input string nm, input [31:0] e, input [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // AXI4-Lite master; waits end on the response or at the 100-cycle bound, which counts as a mismatch
  task axi_wr(input [17:0] ad, input [31:0] d, output [1:0] r);
    integer n;
    @(posedge sys_clk_in);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    for (n = 0; r === 2'h3 && n < 100; n++) begin
      @(posedge sys_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task rd_chk(input string nm, input [17:0] ad, input [31:0] e, input [1:0] er);
    integer n;
    logic [1:0] r;
    @(posedge sys_clk_in);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h3;
    for (n = 0; r === 2'h3 && n < 100; n++) begin
      @(posedge sys_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        r = s_axi_rresp;
        chk(nm, e, s_axi_rdata);
        s_axi_rready <= 1'b0;
      end
    end
    chk(nm, er, r);
  endtask
  task wr_chk(input string nm, input [17:0] ad, input [31:0] d, input [1:0] er);
    logic [1:0] r;
    axi_wr(ad, d, r);
    chk(nm, er, r);
  endtask
  task wait_run;
    for (n_st = 0; cpu_reset_out !== 1'b0 && n_st < 5000; n_st++) @(posedge sys_clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #(20000 * 25);
    failures = failures + 1;
    final_report;
  end
  // Each pass resets with a new option byte and pin pattern, then probes every output except reset_pin_oe_out
  initial begin
    {failures, tests_run, nrst_in, ext_low, wait_mode_in, sel, cpu_addr_in} = '0;
    {option_byte_in, port_b_pin_in, port_b_dir_in, port_c_dir_in, s_axi_wstrb} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    for (i = 0; i < 6; i++) begin
      o = OPTS[i];
      s = SELS[i];
      bt = (s[3] | s[2]) & s[1] & ~s[0];
      wd = o[3] & ~bt;
      ed = bt | o[6:5] == 2'h3 ? `OBD_DIV_2 : o[6:5] == 2'h2 ? `OBD_DIV_4 :
           o[6:5] == 2'h1 ? `OBD_DIV_8 : `OBD_DIV_10;
      @(posedge sys_clk_in);
      nrst_in <= 1'b0;
      option_byte_in <= o;
      sel <= s;
      s_axi_wstrb <= 4'hF;
      repeat (6) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      wait_run;
      chk("stretch", 1, n_st >= (o[4] ? 16 : 4064) && n_st <= (o[4] ? 24 : 4072));
      chk("boot", bt, boot_mode_out);
      chk("div", ed, clock_div_out);
      chk("vector", bt ? `OBD_BOOT_VEC : `OBD_USER_VEC, reset_vector_out);
      chk("wdog", wd, watchdog_run_out);
      chk("pin_drv", 0, reset_pin_out);
      wait_mode_in <= 1'b1;
      port_b_dir_in <= 8'h0F;
      port_c_dir_in <= 8'h3C;
      port_b_pin_in <= 8'h5A;
      cpu_addr_in <= `OBD_ROM3_LO;
      repeat (3) @(posedge sys_clk_in);
      chk("wdog_wait", wd & o[2], watchdog_run_out);
      chk("pd_b", o[1] ? 8'hF0 : 8'h00, port_b_pulldown_out);
      chk("pd_c", o[0] ? 8'hC3 : 8'h00, port_c_pulldown_out);
      chk("rom_in", bt, boot_rom_sel_out);
      wait_mode_in <= 1'b0;
      cpu_addr_in <= `OBD_IDX_OPTION;
      rd_chk("option", A_OPT, {24'h00_0000, o}, `OBD_RESP_OKAY);
      rd_chk("status", A_ST, {24'h00_0000, ed, 2'h0, wd, bt}, `OBD_RESP_OKAY);
      chk("rom_out", 0, boot_rom_sel_out);
      wr_chk("ctrl_wr", A_CTL, 1, `OBD_RESP_OKAY);
      rd_chk("ctrl", A_CTL, o[7], `OBD_RESP_OKAY);
      repeat (2) @(posedge sys_clk_in);
      chk("irq_on", o[7], wired_or_irq_out);
      port_b_pin_in <= 8'hF0;
      repeat (3) @(posedge sys_clk_in);
      chk("irq_off", 0, wired_or_irq_out);
      if (i == 0) begin
        rd_chk("unmapped", 18'h0_0100, 0, `OBD_RESP_SLVERR);
        wr_chk("opt_wr", A_OPT, 0, `OBD_RESP_SLVERR);
        // A write without the low byte lane must leave the soft enable alone
        s_axi_wstrb <= 4'hE;
        wr_chk("ctrl_nostrb", A_CTL, 0, `OBD_RESP_OKAY);
        rd_chk("ctrl_keep", A_CTL, o[7], `OBD_RESP_OKAY);
        ext_low <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        chk("ext_rst", 1, cpu_reset_out);
        ext_low <= 1'b0;
        wait_run;
        rd_chk("ctrl_ext", A_CTL, 0, `OBD_RESP_OKAY);
        rd_chk("opt_ext", A_OPT, {24'h00_0000, o}, `OBD_RESP_OKAY);
        chk("div_ext", ed, clock_div_out);
        chk("wdog_ext", wd, watchdog_run_out);
      end
      $display("test %0d done", i);
    end
    final_report;
  end
endmodule
`default_nettype wire
